// >>> inc/ssec_pkg.sv
// Purpose: shared constants and types of the sensor serial port and exposure sequencer
// Assumes: register index n sits at AHB byte address 4*n; serial address equals the index
// Notes: reset values of the timing registers are plain defaults
package ssec_pkg;
  localparam int NREG = 10;
  localparam int NWR = 9;
  localparam logic [8:0] REG_CTRL = 9'h000;
  localparam logic [8:0] REG_TIMER_MULT = 9'h001;
  localparam logic [8:0] REG_FRAME_TIME_COUNT = 9'h002;
  localparam logic [8:0] REG_EXPOSURE = 9'h003;
  localparam logic [8:0] REG_RESET_LEN = 9'h004;
  localparam logic [8:0] REG_LINE_LEN = 9'h005;
  localparam logic [8:0] REG_LINES = 9'h006;
  localparam logic [8:0] REG_ROW_OVERHEAD_TIME = 9'h007;
  localparam logic [8:0] REG_FRAME_OVERHEAD_TIME = 9'h008;
  localparam logic [8:0] REG_STATUS = 9'h009;
  localparam logic [8:0] REG_NONE = 9'h1FF;
  localparam int AHB_IDX_LSB = 2;
  localparam int AHB_IDX_MSB = 10;
  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FRAME_TIME_MODE_SEL_BIT = 2;
  localparam int CTRL_ENABLE_BIT = 3;
  localparam int CTRL_MON_SEL_LSB = 4;
  localparam logic [1:0] MODE_PIPELINED = 2'h0;
  localparam logic [1:0] MODE_TRIG_MASTER = 2'h1;
  localparam logic [1:0] MODE_TRIG_SLAVE = 2'h2;
  localparam logic [2:0] MON_SEL_FIRST_LINE = 3'h5;
  // index 8 first, index 0 last
  localparam logic [NWR-1:0][15:0] CFG_RESET = {
    16'h0020, 16'h0008, 16'h0400, 16'h0040, 16'h0010,
    16'h0100, 16'h0800, 16'h0001, 16'h0000};
  // serial frame: 9 address bits, direction bit, 16 data bits
  localparam logic [4:0] SPI_ADDR_BITS = 5'h09;
  localparam logic [4:0] SPI_DIR_BIT = 5'h0A;
  localparam logic [4:0] SPI_LAST_BIT = 5'h1A;
  typedef enum logic [2:0] {EXP_IDLE, EXP_RESET, EXP_WAIT_LINE, EXP_EXPOSE, EXP_EXTEND} ssec_exp_t;
  typedef enum logic [1:0] {RO_IDLE, RO_FRAME_OVH, RO_ROW_OVH, RO_LINE} ssec_ro_t;
endpackage

// >>> hw/ssec_spi_slave.sv
// Purpose: four-wire serial register port, oversampled by the system clock
// Assumes: sck well below a quarter of hclk; mosi changes on sck falling edges
// Notes: completed writes leave as a one-cycle pulse in the hclk domain
`timescale 1ns/1ps
module ssec_spi_slave
  import ssec_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic [15:0] rd_data,
  output logic [8:0] addr,
  output logic [15:0] wdata,
  output logic wr_pulse,
  output logic miso,
  output logic miso_oe
);
  typedef struct packed {
    logic [2:0] sck_s;
    logic [1:0] ss_s;
    logic [1:0] mosi_s;
    logic [4:0] bitcnt;
    logic is_read;
    logic [8:0] addr;
    logic [15:0] shift;
    logic wr_pulse;
    logic miso;
    logic miso_oe;
  } ssec_spi_t;

  ssec_spi_t s;
  ssec_spi_t next_s;
  logic sck_rise;
  logic bit_in;
  logic [4:0] cnt_inc;

  always_comb begin
    next_s = s;
    next_s.sck_s = {s.sck_s[1:0], sck};
    next_s.ss_s = {s.ss_s[0], ss_n};
    next_s.mosi_s = {s.mosi_s[0], mosi};
    next_s.wr_pulse = 1'b0;
    // edge seen on synchronised stages only
    sck_rise = s.sck_s[1] & ~s.sck_s[2];
    bit_in = s.mosi_s[1];
    cnt_inc = s.bitcnt + 5'h01;
    // RULE1: select frames access
    if (s.ss_s[1]) begin
      next_s.bitcnt = 5'h00;
      next_s.is_read = 1'b0;
      next_s.miso = 1'b0;
      next_s.miso_oe = 1'b0;
    end else if (sck_rise && s.bitcnt != SPI_LAST_BIT) begin
      next_s.bitcnt = cnt_inc;
      // RULE4: sample on rising edge
      if (s.bitcnt < SPI_ADDR_BITS) begin
        // RULE2: nine address bits
        next_s.addr = {s.addr[7:0], bit_in};
      end else if (s.bitcnt == SPI_ADDR_BITS) begin
        // RULE5: direction bit decode
        next_s.is_read = ~bit_in;
        if (!bit_in) begin
          // RULE7: drive read data
          next_s.shift = rd_data;
          next_s.miso = rd_data[15];
          next_s.miso_oe = 1'b1;
        end
      end else if (s.is_read) begin
        next_s.shift = {s.shift[14:0], 1'b0};
        next_s.miso = s.shift[14];
        if (cnt_inc == SPI_LAST_BIT) begin
          next_s.miso_oe = 1'b0;
        end
      end else begin
        // RULE6: sixteen data bits in
        next_s.shift = {s.shift[14:0], bit_in};
        if (cnt_inc == SPI_LAST_BIT) begin
          next_s.wr_pulse = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.ss_s <= 2'h3;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign addr = s.addr;
  assign wdata = s.shift;
  assign wr_pulse = s.wr_pulse;
  assign miso = s.miso;
  assign miso_oe = s.miso_oe;

  a_select_idle: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
    ce && s.ss_s[1] |=> s.bitcnt == 5'h00 && !s.miso_oe)
    else $error("deselect did not clear the serial port");
  a_rise_capture: assert property (@(posedge hclk) disable iff (!hresetn) // RULE4
    ce && !s.ss_s[1] && sck_rise && s.bitcnt < SPI_ADDR_BITS |=> s.addr[0] == $past(s.mosi_s[1]))
    else $error("address bit not taken on sck rise");
  a_read_drive: assert property (@(posedge hclk) disable iff (!hresetn) // RULE7
    $rose(s.miso_oe) |-> s.is_read && s.bitcnt == SPI_DIR_BIT)
    else $error("miso driven outside a read data phase");
  a_write_word: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
    s.wr_pulse |-> s.bitcnt == SPI_LAST_BIT && !s.is_read && $past(s.bitcnt) == 5'h19)
    else $error("write pulse without sixteen data bits");
endmodule

// >>> hw/ssec_sensor_ctrl.sv
// Purpose: register file on AHB-Lite and serial port, plus global shutter exposure sequencer
// Assumes: one base timer unit is one hclk cycle; readout is modelled by line timing registers
// Notes: all outputs are registered; ce low freezes every flip-flop
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
// How it works
// RULE1: low select starts access, sck asynchronous
// RULE2: nine-bit address, sixteen-bit data word
// RULE3: master shifts address MSB first after select
// RULE4: device samples rising edge, master drives falling
// RULE5: tenth bit high writes, low reads
// RULE6: write data follows, sixteen bits MSB first
// RULE7: read data out MSB first, else released
// RULE8: master deselects one period after last bit
// RULE9: master keeps sck at most sixth of reference
// RULE10: master deselects two periods between accesses
// RULE11: timer counts base cycles times multiplier
// RULE12: pipelined timing from frame and exposure counts
// RULE13: transfer in overhead, reset, then expose
// RULE14: exposure start waits for next line start
// RULE15: pipelined exposure stretched until readout completes
// RULE16: frame time mode derives reset length itself
// RULE17: trigger rise starts timed exposure, frame ignored
// RULE18: master mode ignores falling edge, pulse 100ns
// RULE19: triggered master extends to last line
// RULE20: monitor marks first line when select five
// RULE21: slave: rise exposes, fall transfers and reads
// RULE22: slave early fall extends to last line
// RULE23: serial writes synchronised before sequencer use
module ssec_sensor_ctrl
  import ssec_pkg::*;
#(
  parameter int FRAMES_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic spi_sck,
  input wire logic spi_ss_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic shutter_trigger_in,
  output logic first_monitor_out,
  output logic pd_reset_out,
  output logic exposing_out,
  output logic readout_busy_out
);
  if (FRAMES_W < 1 || FRAMES_W > 8) begin : g_bad_width
    $error("FRAMES_W must be 1 to 8");
  end

  typedef struct packed {
    logic [NWR-1:0][15:0] cfg;
    logic wr_pend;
    logic [8:0] wr_idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [2:0] trig_s;
    ssec_exp_t exp_st;
    logic [31:0] exp_cnt;
    logic fall_seen;
    ssec_ro_t ro_st;
    logic [15:0] ro_cnt;
    logic [15:0] line_idx;
    logic line_start;
    logic [FRAMES_W-1:0] frames;
    logic pd_reset;
    logic exposing;
    logic ro_busy;
    logic monitor;
  } ssec_core_t;

  ssec_core_t s;
  ssec_core_t next_s;

  logic [8:0] spi_addr;
  logic [15:0] spi_wdata;
  logic spi_wr;
  logic [15:0] spi_rd_data;
  logic [1:0] mode;
  logic frmode;
  logic en;
  logic [2:0] mon_sel;
  logic trig_rise;
  logic trig_fall;
  logic [31:0] exp_target;
  logic [31:0] frame_units;
  logic [31:0] rst_target;
  logic [15:0] status;
  logic ahb_take;
  logic [8:0] ahb_idx;
  logic ro_busy_c;
  logic timer_done;
  logic exp_done;
  logic xfer;

  function automatic logic [15:0] ssec_read(input logic [8:0] idx,
                                            input logic [NWR-1:0][15:0] cfg,
                                            input logic [15:0] stat);
    if (idx < 9'(NWR)) begin
      return cfg[idx[3:0]];
    end else if (idx == REG_STATUS) begin
      return stat;
    end
    return 16'h0000;
  endfunction

  // RULE11: count times multiplier
  function automatic logic [31:0] ssec_units(input logic [15:0] count,
                                             input logic [15:0] mult);
    return {16'h0000, count} * {16'h0000, mult};
  endfunction

  function automatic logic ssec_last(input logic [15:0] cnt, input logic [15:0] len);
    return ({1'b0, cnt} + 17'h00001) >= {1'b0, len};
  endfunction

  // RULE23: serial writes arrive synchronised
  ssec_spi_slave u_spi (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .sck(spi_sck),
    .ss_n(spi_ss_n),
    .mosi(spi_mosi),
    .rd_data(spi_rd_data),
    .addr(spi_addr),
    .wdata(spi_wdata),
    .wr_pulse(spi_wr),
    .miso(spi_miso),
    .miso_oe(spi_miso_oe)
  );

  assign mode = s.cfg[REG_CTRL][CTRL_MODE_LSB +: 2];
  assign frmode = s.cfg[REG_CTRL][CTRL_FRAME_TIME_MODE_SEL_BIT];
  assign en = s.cfg[REG_CTRL][CTRL_ENABLE_BIT];
  assign mon_sel = s.cfg[REG_CTRL][CTRL_MON_SEL_LSB +: 3];
  assign status = {8'(s.frames), s.ro_busy, s.pd_reset, s.exposing, 2'h0, s.exp_st};
  assign spi_rd_data = ssec_read(spi_addr, s.cfg, status);
  assign ahb_take = hsel && htrans[1] && hready;
  assign ahb_idx = (haddr[31:AHB_IDX_MSB+1] != '0) ? REG_NONE : haddr[AHB_IDX_MSB:AHB_IDX_LSB];
  assign trig_rise = s.trig_s[1] & ~s.trig_s[2];
  assign trig_fall = ~s.trig_s[1] & s.trig_s[2];
  assign ro_busy_c = s.ro_st != RO_IDLE;
  // RULE12: frame and exposure counts
  assign exp_target = ssec_units(s.cfg[REG_EXPOSURE], s.cfg[REG_TIMER_MULT]);
  assign frame_units = ssec_units(s.cfg[REG_FRAME_TIME_COUNT], s.cfg[REG_TIMER_MULT]);
  // RULE16: reset derived from frame
  assign rst_target = !frmode ? ssec_units(s.cfg[REG_RESET_LEN], s.cfg[REG_TIMER_MULT]) :
                      (frame_units > exp_target) ? frame_units - exp_target : 32'h00000000;
  assign timer_done = s.exp_cnt >= exp_target;

  always_comb begin
    next_s = s;
    exp_done = 1'b0;
    xfer = 1'b0;
    next_s.trig_s = {s.trig_s[1:0], shutter_trigger_in};
    next_s.line_start = 1'b0;
    // bus data phase write, serial write after it
    next_s.wr_pend = 1'b0;
    if (s.wr_pend && s.wr_idx < 9'(NWR)) begin
      next_s.cfg[s.wr_idx[3:0]] = hwdata[15:0];
    end
    if (spi_wr && spi_addr < 9'(NWR)) begin
      next_s.cfg[spi_addr[3:0]] = spi_wdata;
    end
    if (ahb_take) begin
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
        next_s.wr_idx = ahb_idx;
      end else if (s.wr_pend && s.wr_idx == ahb_idx && ahb_idx < 9'(NWR)) begin
        // back-to-back write then read of one register would otherwise read stale
        next_s.hrdata = {16'h0000, hwdata[15:0]};
      end else begin
        next_s.hrdata = {16'h0000, ssec_read(ahb_idx, s.cfg, status)};
      end
    end
    // readout model: overhead, then row overhead plus line body per line
    unique case (s.ro_st)
      RO_IDLE: begin
      end
      RO_FRAME_OVH: begin
        next_s.ro_cnt = s.ro_cnt + 16'h0001;
        if (ssec_last(s.ro_cnt, s.cfg[REG_FRAME_OVERHEAD_TIME])) begin
          next_s.ro_st = RO_ROW_OVH;
          next_s.ro_cnt = 16'h0000;
          next_s.line_idx = 16'h0000;
          next_s.line_start = 1'b1;
        end
      end
      RO_ROW_OVH: begin
        next_s.ro_cnt = s.ro_cnt + 16'h0001;
        if (ssec_last(s.ro_cnt, s.cfg[REG_ROW_OVERHEAD_TIME])) begin
          next_s.ro_st = RO_LINE;
          next_s.ro_cnt = 16'h0000;
        end
      end
      RO_LINE: begin
        next_s.ro_cnt = s.ro_cnt + 16'h0001;
        if (ssec_last(s.ro_cnt, s.cfg[REG_LINE_LEN])) begin
          next_s.ro_cnt = 16'h0000;
          if (ssec_last(s.line_idx, s.cfg[REG_LINES])) begin
            next_s.ro_st = RO_IDLE;
          end else begin
            next_s.ro_st = RO_ROW_OVH;
            next_s.line_idx = s.line_idx + 16'h0001;
            next_s.line_start = 1'b1;
          end
        end
      end
    endcase
    if (!en) begin
      next_s.exp_st = EXP_IDLE;
    end else begin
      unique case (s.exp_st)
        EXP_IDLE: begin
          next_s.exp_cnt = 32'h00000000;
          if (mode == MODE_PIPELINED) begin
            next_s.exp_st = EXP_RESET;
          // RULE17: rise starts integration
          end else if (trig_rise && (mode == MODE_TRIG_MASTER || mode == MODE_TRIG_SLAVE)) begin
            next_s.exp_st = EXP_WAIT_LINE;
            next_s.fall_seen = 1'b0;
          end
        end
        EXP_RESET: begin
          // RULE13: reset after overhead transfer
          if (s.ro_st != RO_FRAME_OVH) begin
            next_s.exp_cnt = s.exp_cnt + 32'h00000001;
            if (s.exp_cnt >= rst_target) begin
              next_s.exp_st = EXP_WAIT_LINE;
            end
          end
        end
        EXP_WAIT_LINE: begin
          // RULE14: start at line start, or at once when readout is idle
          if (!ro_busy_c || s.line_start) begin
            next_s.exp_st = EXP_EXPOSE;
            next_s.exp_cnt = 32'h00000000;
          end
        end
        EXP_EXPOSE: begin
          next_s.exp_cnt = s.exp_cnt + 32'h00000001;
          // RULE21: slave ends on fall
          exp_done = (mode == MODE_TRIG_SLAVE) ? s.fall_seen : timer_done;
          if (exp_done) begin
            // RULE15: stretch past readout
            // RULE19: extend to last line
            // RULE22: early fall also extends
            if (ro_busy_c) begin
              next_s.exp_st = EXP_EXTEND;
            end else begin
              xfer = 1'b1;
            end
          end
        end
        EXP_EXTEND: begin
          if (!ro_busy_c) begin
            xfer = 1'b1;
          end
        end
        default: begin
          next_s.exp_st = EXP_IDLE;
        end
      endcase
    end
    // RULE18: fall only counts in slave mode
    if (mode == MODE_TRIG_SLAVE && trig_fall) begin
      next_s.fall_seen = 1'b1;
    end
    if (xfer) begin
      next_s.ro_st = RO_FRAME_OVH;
      next_s.ro_cnt = 16'h0000;
      next_s.frames = s.frames + FRAMES_W'(1);
      next_s.exp_cnt = 32'h00000000;
      next_s.exp_st = (mode == MODE_PIPELINED) ? EXP_RESET : EXP_IDLE;
    end
    next_s.exposing = next_s.exp_st == EXP_EXPOSE || next_s.exp_st == EXP_EXTEND;
    next_s.pd_reset = !next_s.exposing;
    next_s.ro_busy = next_s.ro_st != RO_IDLE;
    // RULE20: first line marker
    next_s.monitor = mon_sel == MON_SEL_FIRST_LINE && next_s.line_idx == 16'h0000 &&
                     (next_s.ro_st == RO_ROW_OVH || next_s.ro_st == RO_LINE);
    next_s.hreadyout = 1'b1;
    next_s.hresp = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.cfg <= CFG_RESET;
      s.hreadyout <= 1'b1;
      s.pd_reset <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hreadyout;
  assign hresp = s.hresp;
  assign first_monitor_out = s.monitor;
  assign pd_reset_out = s.pd_reset;
  assign exposing_out = s.exposing;
  assign readout_busy_out = s.ro_busy;

  a_trig_start: assert property (@(posedge hclk) disable iff (!hresetn) // RULE17
    ce && en && mode == MODE_TRIG_MASTER && s.exp_st == EXP_IDLE && trig_rise
    |=> s.exp_st == EXP_WAIT_LINE)
    else $error("trigger rise did not start exposure");
  a_fall_ignored: assert property (@(posedge hclk) disable iff (!hresetn) // RULE18
    ce && en && mode == MODE_TRIG_MASTER && s.exp_st == EXP_EXPOSE && trig_fall && !timer_done
    |=> s.exp_st == EXP_EXPOSE && s.exposing)
    else $error("falling trigger ended a master exposure");
  a_expose_on_line: assert property (@(posedge hclk) disable iff (!hresetn) // RULE14
    ce && $rose(s.exposing) |-> $past(s.line_start) || !$past(s.ro_busy))
    else $error("exposure began mid line");
  a_extend_readout: assert property (@(posedge hclk) disable iff (!hresetn) // RULE15
    ce && en && s.exp_st == EXP_EXPOSE && mode == MODE_PIPELINED && timer_done && ro_busy_c
    |=> s.exp_st == EXP_EXTEND)
    else $error("exposure not stretched over readout");
  a_extend_last_line: assert property (@(posedge hclk) disable iff (!hresetn) // RULE19
    ce && $fell(s.exposing) && en |-> !$past(s.ro_busy) && s.ro_st == RO_FRAME_OVH)
    else $error("transfer started while lines were read");
  a_slave_extend: assert property (@(posedge hclk) disable iff (!hresetn) // RULE22
    ce && en && mode == MODE_TRIG_SLAVE && s.exp_st == EXP_EXPOSE && s.fall_seen && ro_busy_c
    |=> s.exp_st == EXP_EXTEND && s.exposing)
    else $error("early slave fall not extended");
  a_slave_fall: assert property (@(posedge hclk) disable iff (!hresetn) // RULE21
    ce && en && mode == MODE_TRIG_SLAVE && s.exp_st == EXP_EXPOSE && s.fall_seen && !ro_busy_c
    |=> !s.exposing && s.ro_st == RO_FRAME_OVH)
    else $error("slave fall did not start transfer");
  a_reset_length: assert property (@(posedge hclk) disable iff (!hresetn) // RULE13
    ce && en && s.exp_st == EXP_RESET && s.ro_st != RO_FRAME_OVH && s.exp_cnt < rst_target
    |=> s.exp_st == EXP_RESET && s.pd_reset)
    else $error("photodiode reset released early");
  a_monitor_first: assert property (@(posedge hclk) disable iff (!hresetn) // RULE20
    ce && $rose(first_monitor_out) |-> $past(s.ro_st) == RO_FRAME_OVH && mon_sel == 3'h5)
    else $error("monitor rose away from the first line");
  a_spi_write_sync: assert property (@(posedge hclk) disable iff (!hresetn) // RULE23
    ce && spi_wr && spi_addr == REG_EXPOSURE && !(s.wr_pend && s.wr_idx == REG_EXPOSURE)
    |=> s.cfg[REG_EXPOSURE] == $past(spi_wdata))
    else $error("serial write not applied");
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |-> hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
endmodule

// >>> tb/ssec_spi_master.sv
// Purpose: serial master model for the sensor register port
// Assumes: mosi changes while sck is low; miso is taken on falling edges
// Notes: sck stands low outside accesses; a released miso reads as z here
`timescale 1ns/1ps
module ssec_spi_master (
  input wire logic hclk,
  input wire logic miso,
  input wire logic miso_oe,
  output logic sck,
  output logic ss_n,
  output logic mosi
);
  // 160 ns period, far below the port limit
  localparam int HALF = 20;
  int oe_cnt;
  initial begin
    sck = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic period();
    repeat (2 * HALF) @(posedge hclk);
  endtask
  task automatic access(input logic [8:0] addr, input logic wr, input logic [15:0] wd,
                        output logic [15:0] rd);
    logic [25:0] frame;
    frame = {addr, wr, wd};
    rd = 16'h0000;
    oe_cnt = 0;
    ss_n <= 1'b0;
    // one period before the first bit
    period();
    for (int i = 0; i < 26; i++) begin
      // msb first, driven while sck low
      mosi <= frame[25-i];
      repeat (HALF) @(posedge hclk);
      sck <= 1'b1;
      repeat (HALF) @(posedge hclk);
      sck <= 1'b0;
      if (i >= 9 && i <= 24) begin
        // read bits taken on falling edges
        rd = {rd[14:0], miso};
        oe_cnt += int'(miso_oe);
      end
    end
    // deselect one period after the last bit
    period();
    ss_n <= 1'b1;
    mosi <= ~mosi;
    // gap of two periods between accesses
    period();
    period();
  endtask
endmodule

// >>> tb/ssec_sensor_ctrl_bench.sv
// Purpose: register, serial port and shutter sequencer tests
// Assumes: zero-wait AHB slave; small line timing keeps frames short
// Notes: exposure lengths are checked in a window of a few cycles
`timescale 1ns/1ps
module ssec_sensor_ctrl_bench;
  import ssec_pkg::*;
  logic hclk, hresetn, ce, hsel, hwrite, trig;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] sr;
  logic hreadyout, hresp, sck, ss_n, mosi, miso, miso_oe, miso_w, mon, pd_rst, expo, busy;
  int error_cnt = 0;
  int compares = 0;
  int n, lo, idle;
  assign miso_w = miso_oe ? miso : 1'bz;
  ssec_sensor_ctrl u_ssec_sensor_ctrl (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .spi_sck(sck),
    .spi_ss_n(ss_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
    .shutter_trigger_in(trig), .first_monitor_out(mon), .pd_reset_out(pd_rst),
    .exposing_out(expo), .readout_busy_out(busy));
  ssec_spi_master u_ssec_spi_master (.hclk(hclk), .miso(miso_w), .miso_oe(miso_oe),
    .sck(sck), .ss_n(ss_n), .mosi(mosi));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wait_ready();
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
  endtask
  task automatic ahb(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {21'h000000, idx, 2'h0};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  task automatic mode(input logic [31:0] v);
    ahb(1'b1, REG_CTRL, 32'h0);
    repeat (300) @(posedge hclk);
    ahb(1'b1, REG_CTRL, v);
  endtask
  // exposure length, low time before it, and whether readout went idle meanwhile
  task automatic expo_len();
    n = 0;
    lo = 0;
    idle = 0;
    while (expo !== 1'b1) begin
      @(posedge hclk);
      lo++;
    end
    while (expo === 1'b1) begin
      idle |= int'(busy === 1'b0);
      @(posedge hclk);
      n++;
    end
  endtask
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    #60000;
    error_cnt++;
    finish_test();
  end
  initial begin
    {hresetn, hsel, hwrite, trig, htrans, haddr, hwdata} = '0;
    ce = 1'b1;
    hsize = 3'h2;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    check({pd_rst, expo, busy}, 32'h4);
    for (int i = 0; i < NWR; i++) begin
      ahb(1'b0, 9'(i), 32'h0);
      check(r, {16'h0, CFG_RESET[i]});
    end
    // idle state word: only the photodiode reset flag is up
    ahb(1'b0, REG_STATUS, 32'h0);
    check(r, 32'h00000040);
    ahb(1'b1, REG_FRAME_TIME_COUNT, 32'hABCDFFFF);
    ahb(1'b0, REG_FRAME_TIME_COUNT, 32'h0);
    check(r, 32'h0000FFFF);
    ahb(1'b1, 9'h00A, 32'h00001234);
    ahb(1'b0, 9'h00A, 32'h0);
    check(r, 32'h0);
    ahb(1'b1, REG_TIMER_MULT, 32'h2);
    ahb(1'b1, REG_RESET_LEN, 32'h3);
    ahb(1'b1, REG_LINE_LEN, 32'h8);
    ahb(1'b1, REG_LINES, 32'h4);
    ahb(1'b1, REG_ROW_OVERHEAD_TIME, 32'h4);
    ahb(1'b1, REG_FRAME_OVERHEAD_TIME, 32'h8);
    u_ssec_spi_master.access(REG_EXPOSURE, 1'b1, 16'h0014, sr);
    ahb(1'b0, REG_EXPOSURE, 32'h0);
    check(r, 32'h00000014);
    u_ssec_spi_master.access(REG_LINES, 1'b0, 16'hFFFF, sr);
    check({16'h0, sr}, 32'h4);
    check(u_ssec_spi_master.oe_cnt, 16);
    ahb(1'b0, REG_LINES, 32'h0);
    check(r, 32'h4);
    mode(32'h00000059);
    fork
      expo_len();
      begin
        trig <= 1'b1;
        // pulse of 100 ns, falls mid exposure
        repeat (25) @(posedge hclk);
        trig <= 1'b0;
      end
    join
    check(32'(n >= 40 && n <= 42), 32'h1);
    lo = 0;
    while (mon !== 1'b1 && lo < 100) begin
      @(posedge hclk);
      lo++;
    end
    check(32'(lo >= 7 && lo <= 11), 32'h1);
    check({31'h0, busy}, 32'h1);
    fork
      expo_len();
      begin
        trig <= 1'b1;
        repeat (25) @(posedge hclk);
        trig <= 1'b0;
      end
    join
    check(32'(idle), 32'h1);
    ahb(1'b1, REG_TIMER_MULT, 32'h1);
    mode(32'h00000008);
    expo_len();
    expo_len();
    check(32'(idle), 32'h1);
    ahb(1'b1, REG_TIMER_MULT, 32'h2);
    ahb(1'b1, REG_FRAME_TIME_COUNT, 32'h64);
    mode(32'h0000000C);
    expo_len();
    expo_len();
    // frame overhead 8, derived reset 200-40, plus the wait-line step
    check(32'(lo >= 168 && lo <= 172), 32'h1);
    // monitor select 5 so the retrigger can wait for the first line
    mode(32'h0000005A);
    fork
      expo_len();
      begin
        trig <= 1'b1;
        repeat (200) @(posedge hclk);
        trig <= 1'b0;
      end
    join
    check(32'(n >= 197 && n <= 203), 32'h1);
    repeat (3) @(posedge hclk);
    check({31'h0, busy}, 32'h1);
    // trigger must stay low through the frame overhead
    while (mon !== 1'b1) begin
      @(posedge hclk);
    end
    fork
      expo_len();
      begin
        trig <= 1'b1;
        repeat (25) @(posedge hclk);
        trig <= 1'b0;
      end
    join
    check(32'(idle), 32'h1);
    finish_test();
  end
endmodule
